/* hw/ecl_loader.v */
// Configuration image loader: reads the serial memory and holds settings
`timescale 1ns/1ps
`include "ecl_defs.vh"

// Summary of operation
// - All-erased station bytes select built-in defaults
// - Station address from bytes zero to five
// - Max power from byte eight
// - Poll interval byte nine, zero disables endpoint
// - Byte ten bit one selects internal transceiver
// - PHY select from byte ten bits four:two
// - Led_indication_select from byte eleven bits seven:six
// - Language code from bytes twelve, thirteen
// - Vendor code from bytes sixteen, seventeen
// - Product code from bytes eighteen, nineteen
// - String lengths from bytes twenty, 22, 24
// - String word offsets doubled to byte addresses
// - Strings returned as full descriptors, type three
module ecl_loader #(
	parameter SK_HALF_CYC = `ECL_SK_HALF_CYC
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        soft_rst_i,
	input  wire        bus_rst_i,
	input  wire        mem_do_i,
	input  wire [1:0]  str_sel_i,
	input  wire [6:0]  str_idx_i,
	input  wire        str_rd_i,
	output reg         mem_cs_o,
	output reg         mem_sk_o,
	output reg         mem_di_o,
	output reg         cfg_ready_o,
	output reg         image_blank_o,
	output reg  [47:0] station_addr_o,
	output reg  [7:0]  max_power_o,
	output reg  [7:0]  intr_endpoint_poll_interval_o,
	output reg         interrupt_in_endpoint_en_o,
	output reg         usb_xcvr_internal_o,
	output reg  [2:0]  phy_operating_select_o,
	output reg         phy_integrated_o,
	output reg  [1:0]  led_indication_select_o,
	output reg  [15:0] lang_code_o,
	output reg  [15:0] vendor_code_o,
	output reg  [15:0] product_code_o,
	output reg  [7:0]  str_len_o,
	output reg  [7:0]  str_data_o,
	output reg         str_valid_o
);
	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_ISSUE = 4'b0010;
	localparam [3:0] ST_WAIT  = 4'b0100;
	localparam [3:0] ST_DONE  = 4'b1000;
	localparam [7:0] LAST_WORD = `ECL_IMG_WORDS - 8'h01;

	reg  [3:0]  state;
	reg  [5:0]  waddr;
	reg  [15:0] img [0:63];
	reg         start;
	reg         soft_s;
	reg         bus_s;
	reg         restart;
	wire        eng_busy;
	wire        eng_done;
	wire [15:0] eng_word;
	wire        eng_cs;
	wire        eng_sk;
	wire        eng_di;
	wire        blank;
	reg  [7:0]  next_byte;
	reg  [7:0]  sel_len;
	reg  [7:0]  sel_base;
	reg  [7:0]  byte_addr;
	integer     i;

	// ----------------------------------------------------------------
	// Reset inputs from other logic pass two flops
	// ----------------------------------------------------------------
	ecl_sync u_soft_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (soft_rst_i),
		.q_o     (soft_s)
	);

	ecl_sync u_bus_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (bus_rst_i),
		.q_o     (bus_s)
	);

	// Serial memory word engine
	ecl_sermem #(
		.SK_HALF_CYC (SK_HALF_CYC)
	) u_mem (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.start_i  (start),
		.addr_i   (waddr),
		.mem_do_i (mem_do_i),
		.busy_o   (eng_busy),
		.done_o   (eng_done),
		.word_o   (eng_word),
		.mem_cs_o (eng_cs),
		.mem_sk_o (eng_sk),
		.mem_di_o (eng_di)
	);

	// Words are stored little end first: byte 2n low, 2n+1 high
	assign blank = (img[0] == {`ECL_ERASED_BYTE, `ECL_ERASED_BYTE}) &&
	               (img[1] == {`ECL_ERASED_BYTE, `ECL_ERASED_BYTE}) &&
	               (img[2] == {`ECL_ERASED_BYTE, `ECL_ERASED_BYTE});

	// ----------------------------------------------------------------
	// Load sequencer
	// ----------------------------------------------------------------
	// Whole image is fetched so descriptors can be served locally
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state       <= ST_IDLE;
			waddr       <= 6'h00;
			start       <= 1'b0;
			restart     <= 1'b0;
			cfg_ready_o <= 1'b0;
			for (i = 0; i < 64; i = i + 1)
				img[i] <= 16'h0000;
		end else begin
			start <= 1'b0;
			if (soft_s || bus_s) begin
				// Any reset reloads; hold ready low meanwhile
				restart     <= 1'b1;
				cfg_ready_o <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					if (!(soft_s || bus_s)) begin
						waddr   <= 6'h00;
						restart <= 1'b0;
						state   <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (!eng_busy) begin
						start <= 1'b1;
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (eng_done) begin
						img[waddr] <= {eng_word[7:0], eng_word[15:8]};
						if (waddr == LAST_WORD[5:0])
							state <= ST_DONE;
						else begin
							waddr <= waddr + 6'h01;
							state <= ST_ISSUE;
						end
					end
				end
				ST_DONE: begin
					if (restart || soft_s || bus_s)
						state <= ST_IDLE;
					else
						cfg_ready_o <= 1'b1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Memory pins registered once more so outputs come from flops
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mem_cs_o <= 1'b0;
			mem_sk_o <= 1'b0;
			mem_di_o <= 1'b0;
		end else begin
			mem_cs_o <= eng_cs;
			mem_sk_o <= eng_sk;
			mem_di_o <= eng_di;
		end
	end

	// ----------------------------------------------------------------
	// Configuration fields, updated once loading completes
	// ----------------------------------------------------------------
	// Reserved bytes 06-07, 0E-0F and reserved bits never read
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			image_blank_o                 <= 1'b0;
			station_addr_o                <= `ECL_DEF_STATION;
			max_power_o                   <= `ECL_DEF_MAX_PWR;
			intr_endpoint_poll_interval_o <= `ECL_DEF_POLL;
			interrupt_in_endpoint_en_o    <= 1'b1;
			usb_xcvr_internal_o           <= `ECL_DEF_XCVR_INT;
			phy_operating_select_o        <= `ECL_DEF_PHY_SEL;
			phy_integrated_o              <= 1'b1;
			led_indication_select_o       <= `ECL_DEF_LED_SEL;
			lang_code_o                   <= `ECL_DEF_LANG;
			vendor_code_o                 <= `ECL_DEF_VEND;
			product_code_o                <= `ECL_DEF_PROD;
		end else if (state == ST_WAIT && eng_done &&
		             waddr == LAST_WORD[5:0]) begin
			image_blank_o <= blank;
			if (blank) begin
				// Blank image: keep every field at its default
				station_addr_o                <= `ECL_DEF_STATION;
				max_power_o                   <= `ECL_DEF_MAX_PWR;
				intr_endpoint_poll_interval_o <= `ECL_DEF_POLL;
				interrupt_in_endpoint_en_o    <= 1'b1;
				usb_xcvr_internal_o           <= `ECL_DEF_XCVR_INT;
				phy_operating_select_o        <= `ECL_DEF_PHY_SEL;
				phy_integrated_o              <= 1'b1;
				led_indication_select_o       <= `ECL_DEF_LED_SEL;
				lang_code_o                   <= `ECL_DEF_LANG;
				vendor_code_o                 <= `ECL_DEF_VEND;
				product_code_o                <= `ECL_DEF_PROD;
			end else begin
				// First image byte lands in the top of the address
				station_addr_o <= {img[0][7:0], img[0][15:8],
				                   img[1][7:0], img[1][15:8],
				                   img[2][7:0], img[2][15:8]};
				max_power_o <= img[4][7:0];
				intr_endpoint_poll_interval_o <= img[4][15:8];
				interrupt_in_endpoint_en_o <=
					(img[4][15:8] != 8'h00);
				usb_xcvr_internal_o <= img[5][`ECL_XCVR_BIT];
				phy_operating_select_o <=
					img[5][`ECL_PHY_MSB:`ECL_PHY_LSB];
				phy_integrated_o <=
					(img[5][`ECL_PHY_MSB:`ECL_PHY_LSB] == 3'h0);
				led_indication_select_o <=
					img[5][8+`ECL_LED_MSB:8+`ECL_LED_LSB];
				lang_code_o    <= {img[6][15:8], img[6][7:0]};
				vendor_code_o  <= {img[8][15:8], img[8][7:0]};
				product_code_o <= {img[9][15:8], img[9][7:0]};
			end
		end
	end

	// ----------------------------------------------------------------
	// String descriptor port
	// ----------------------------------------------------------------
	// Length and word offset for the chosen string, blank means none
	always @* begin
		case (str_sel_i)
			2'd0: begin
				sel_len  = img[10][7:0];
				sel_base = {img[10][14:8], 1'b0};
			end
			2'd1: begin
				sel_len  = img[11][7:0];
				sel_base = {img[11][14:8], 1'b0};
			end
			2'd2: begin
				sel_len  = img[12][7:0];
				sel_base = {img[12][14:8], 1'b0};
			end
			default: begin
				sel_len  = 8'h00;
				sel_base = 8'h00;
			end
		endcase
		if (blank) begin
			sel_len  = 8'h00;
			sel_base = 8'h00;
		end
		byte_addr = sel_base + {1'b0, str_idx_i};
		if (byte_addr[0])
			next_byte = img[byte_addr[6:1]][15:8];
		else
			next_byte = img[byte_addr[6:1]][7:0];
		// Header bytes made here so a wrong stored header cannot leak
		if (str_idx_i == 7'd0)
			next_byte = sel_len;
		else if (str_idx_i == 7'd1)
			next_byte = `ECL_STR_DESC_TYPE;
	end

	// Reads answered only once the image is loaded
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			str_len_o   <= 8'h00;
			str_data_o  <= 8'h00;
			str_valid_o <= 1'b0;
		end else begin
			str_valid_o <= str_rd_i && cfg_ready_o;
			if (str_rd_i && cfg_ready_o) begin
				str_len_o  <= sel_len;
				str_data_o <= next_byte;
			end
		end
	end
endmodule

/* hw/ecl_defs.vh */
// Constants for the configuration image loader
`ifndef ECL_DEFS_VH
`define ECL_DEFS_VH

// ----------------------------------------------------------------
// Image layout (byte offsets)
// ----------------------------------------------------------------
`define ECL_OFS_STATION0    8'h00
`define ECL_OFS_STATION5    8'h05
`define ECL_OFS_MAX_PWR     8'h08
`define ECL_OFS_POLL        8'h09
`define ECL_OFS_XCVR_PHY    8'h0A
`define ECL_OFS_LED         8'h0B
`define ECL_OFS_LANG_LO     8'h0C
`define ECL_OFS_LANG_HI     8'h0D
`define ECL_OFS_VEND_LO     8'h10
`define ECL_OFS_VEND_HI     8'h11
`define ECL_OFS_PROD_LO     8'h12
`define ECL_OFS_PROD_HI     8'h13
`define ECL_OFS_MSTR_LEN    8'h14
`define ECL_OFS_MSTR_WOFS   8'h15
`define ECL_OFS_PSTR_LEN    8'h16
`define ECL_OFS_PSTR_WOFS   8'h17
`define ECL_OFS_SSTR_LEN    8'h18
`define ECL_OFS_SSTR_WOFS   8'h19
`define ECL_HDR_WORDS       8'h0D
`define ECL_IMG_WORDS       8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ECL_XCVR_BIT        1
`define ECL_PHY_MSB         4
`define ECL_PHY_LSB         2
`define ECL_LED_MSB         7
`define ECL_LED_LSB         6
`define ECL_ERASED_BYTE     8'hFF
`define ECL_STR_DESC_TYPE   8'h03

// ----------------------------------------------------------------
// Defaults used when the image is blank
// ----------------------------------------------------------------
`define ECL_DEF_STATION     48'h00_00_00_00_00_01
`define ECL_DEF_MAX_PWR     8'h32
`define ECL_DEF_POLL        8'h01
`define ECL_DEF_XCVR_INT    1'b1
`define ECL_DEF_PHY_SEL     3'h0
`define ECL_DEF_LED_SEL     2'h0
`define ECL_DEF_LANG        16'h0001
`define ECL_DEF_VEND        16'h1234
`define ECL_DEF_PROD        16'h5678

// ----------------------------------------------------------------
// Serial memory timing: 1 MHz max shift clock at 100 MHz
// ----------------------------------------------------------------
`define ECL_CLK_NS          10
`define ECL_SK_HALF_NS      500
`define ECL_SK_HALF_CYC     (`ECL_SK_HALF_NS / `ECL_CLK_NS)
`define ECL_READ_OP         3'h6

`endif

/* hw/ecl_sync.v */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module ecl_sync (
	input  wire clk_i,
	input  wire rst_b_i,
	input  wire d_i,
	output reg  q_o
);
	reg meta;

	// First stage feeds only the second
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= 1'b0;
			q_o  <= 1'b0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

/* hw/ecl_sermem.v */
// Microwire style word reader for the serial configuration memory
`timescale 1ns/1ps
`include "ecl_defs.vh"
module ecl_sermem #(
	parameter SK_HALF_CYC = `ECL_SK_HALF_CYC
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        start_i,
	input  wire [5:0]  addr_i,
	input  wire        mem_do_i,
	output reg         busy_o,
	output reg         done_o,
	output reg  [15:0] word_o,
	output reg         mem_cs_o,
	output reg         mem_sk_o,
	output reg         mem_di_o
);
	// Sequence: start bit + opcode + 6 addr bits, dummy zero, 16 data bits
	localparam [5:0] NBITS     = 6'd25;
	localparam integer HALF_LAST = SK_HALF_CYC - 1;

	reg        sk_rise;
	reg [7:0]  tick;
	reg [5:0]  bitn;
	reg [8:0]  cmd;
	reg        data_in;

	// Synchronised data line from the memory
	ecl_sync u_do_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (mem_do_i),
		.q_o     (data_in)
	);

	// Shift engine; SK period of two half periods keeps to 1 MHz at most
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_o   <= 1'b0;
			done_o   <= 1'b0;
			word_o   <= 16'h0000;
			mem_cs_o <= 1'b0;
			mem_sk_o <= 1'b0;
			mem_di_o <= 1'b0;
			tick     <= 8'h00;
			bitn     <= 6'h00;
			cmd      <= 9'h000;
			sk_rise  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!busy_o) begin
				if (start_i) begin
					busy_o   <= 1'b1;
					mem_cs_o <= 1'b1;
					// First command bit goes out with the select
					{mem_di_o, cmd} <= {`ECL_READ_OP, addr_i, 1'b0};
					bitn     <= 6'h00;
					tick     <= 8'h00;
					sk_rise  <= 1'b1;
				end
			end else if (tick != HALF_LAST[7:0]) begin
				tick <= tick + 8'h01;
			end else begin
				tick <= 8'h00;
				if (sk_rise) begin
					// DI moved half a period ago, so it is steady here
					mem_sk_o <= 1'b1;
					sk_rise  <= 1'b0;
				end else begin
					// Data sampled late in high phase for output delay
					mem_sk_o <= 1'b0;
					sk_rise  <= 1'b1;
					// Next command bit on the fall; zeros once spent
					mem_di_o <= cmd[8];
					cmd      <= {cmd[7:0], 1'b0};
					if (bitn > 6'd9)
						word_o <= {word_o[14:0], data_in};
					if (bitn == NBITS) begin
						busy_o   <= 1'b0;
						done_o   <= 1'b1;
						mem_cs_o <= 1'b0;
					end
					bitn <= bitn + 6'h01;
				end
			end
		end
	end
endmodule

/* testbench/ecl_mem_model.sv */
// Behavioural serial configuration memory answering word reads
`timescale 1ns/1ps
`include "ecl_defs.vh"
module ecl_mem_model (
	input  logic cs_i,
	input  logic sk_i,
	input  logic di_i,
	output logic do_o
);
	logic [7:0]  img [0:127];
	logic [8:0]  cmd;
	logic [4:0]  cnt;
	logic [15:0] word;

	// ----------------------------------------------------------------
	// Command shift-in, then dummy zero and data MSB first
	// ----------------------------------------------------------------
	initial do_o = 1'b0;
	// Data changes on SK rise so it is steady at the loader's SK fall
	always @(posedge sk_i or negedge cs_i) begin
		if (!cs_i) begin
			cnt  <= 5'h00;
			do_o <= ~do_o; // Released line must not show a stale bit
		end else begin
			if (cnt < 5'h09)
				cmd <= {cmd[7:0], di_i};
			if (cnt == 5'h09) begin
				do_o <= 1'b0; // Dummy bit
				// A wrong opcode returns junk so the bench sees it
				word <= (cmd[8:6] == `ECL_READ_OP) ?
					{img[{cmd[5:0], 1'b0}], img[{cmd[5:0], 1'b1}]} :
					16'hDEAD;
			end else if (cnt > 5'h09 && cnt < 5'h1A) begin
				do_o <= word[15];
				word <= {word[14:0], 1'b0};
			end
			if (cnt < 5'h1F)
				cnt <= cnt + 5'h01;
		end
	end
endmodule

/* testbench/ecl_loader_checker.sv */
// Property checker for the configuration image loader
`timescale 1ns/1ps
`include "ecl_defs.vh"
module ecl_loader_checker (
	input logic        clk_i,
	input logic        rst_b_i,
	input logic        bus_rst_i,
	input logic        str_rd_i,
	input logic        mem_cs_o,
	input logic        mem_sk_o,
	input logic        cfg_ready_o,
	input logic        image_blank_o,
	input logic [47:0] station_addr_o,
	input logic [7:0]  max_power_o,
	input logic [7:0]  intr_endpoint_poll_interval_o,
	input logic        interrupt_in_endpoint_en_o,
	input logic [2:0]  phy_operating_select_o,
	input logic        phy_integrated_o,
	input logic [7:0]  str_data_o,
	input logic        str_valid_o
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// String port answers one cycle after a taken strobe
	a_rd_answered: assert property (
		str_rd_i && cfg_ready_o |=> str_valid_o)
		else $error("string read not answered");
	a_no_stray: assert property (
		str_valid_o |-> $past(str_rd_i) && $past(cfg_ready_o))
		else $error("string valid without a taken read");
	a_data_held: assert property (
		cfg_ready_o && $past(cfg_ready_o) && !$past(str_rd_i)
		|-> $stable(str_data_o))
		else $error("string data moved without a read");
	// Derived flags must agree with their fields
	a_poll_gate: assert property (cfg_ready_o |->
		interrupt_in_endpoint_en_o == (intr_endpoint_poll_interval_o != 8'h00))
		else $error("endpoint enable disagrees with interval");
	a_phy_flag: assert property (cfg_ready_o |->
		phy_integrated_o == (phy_operating_select_o == 3'h0))
		else $error("integrated phy flag wrong");
	a_blank_dflt: assert property (cfg_ready_o && image_blank_o |->
		station_addr_o == `ECL_DEF_STATION && max_power_o == `ECL_DEF_MAX_PWR)
		else $error("blank image fields not at defaults");
	a_fields_held: assert property (
		cfg_ready_o && $past(cfg_ready_o) |-> $stable(station_addr_o))
		else $error("station address moved while loaded");
	a_reload_drop: assert property (
		$rose(bus_rst_i) |-> ##[1:4] !cfg_ready_o)
		else $error("ready kept after bus reset");
	// Chip select settles before the first shift clock
	a_cs_setup: assert property (
		$rose(mem_cs_o) |-> !mem_sk_o [*8])
		else $error("shift clock too soon after select");

	c_read: cover property (str_valid_o);
	c_blank: cover property ($rose(cfg_ready_o) && image_blank_o);
	c_prog: cover property ($rose(cfg_ready_o) && !image_blank_o);
endmodule

/* testbench/test_eeprom_config_image_loader.sv */
// Self-checking bench for the configuration image loader
`timescale 1ns/1ps
`include "ecl_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end
module test_eeprom_config_image_loader;
	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        bus_rst_i = 1'b0;
	logic        str_rd_i = 1'b0;
	logic [1:0]  str_sel_i = 2'h0;
	logic [6:0]  str_idx_i = 7'h00;
	wire         mem_do, mem_cs, mem_sk, mem_di;
	wire         ready, blank, xcvr, en, integ, valid;
	wire [47:0]  station;
	wire [7:0]   power, poll, slen, sdata;
	wire [2:0]   phy;
	wire [1:0]   led;
	wire [15:0]  lang, vend, prod;
	wire [15:0]  sword = {slen, sdata};
	logic [15:0] want;
	logic [7:0]  img [0:127];
	logic [15:0] exp_q [$];
	int          errors = 0, cmp_count = 0, seed = 32'hDD1922F8;

	// Shorter shift half period keeps two full loads inside the run budget
	ecl_loader #(.SK_HALF_CYC(10)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.soft_rst_i(1'b0),
		.bus_rst_i(bus_rst_i), .mem_do_i(mem_do), .str_sel_i(str_sel_i),
		.str_idx_i(str_idx_i), .str_rd_i(str_rd_i), .mem_cs_o(mem_cs),
		.mem_sk_o(mem_sk), .mem_di_o(mem_di), .cfg_ready_o(ready),
		.image_blank_o(blank), .station_addr_o(station), .max_power_o(power),
		.intr_endpoint_poll_interval_o(poll), .interrupt_in_endpoint_en_o(en),
		.usb_xcvr_internal_o(xcvr), .phy_operating_select_o(phy),
		.phy_integrated_o(integ), .led_indication_select_o(led),
		.lang_code_o(lang), .vendor_code_o(vend), .product_code_o(prod),
		.str_len_o(slen), .str_data_o(sdata), .str_valid_o(valid));
	ecl_mem_model u_mem (.cs_i(mem_cs), .sk_i(mem_sk), .di_i(mem_di),
		.do_o(mem_do));

	always #5 clk_i = ~clk_i;

	// Each answer is matched with the oldest note
	always @(posedge clk_i) begin
		if (valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(valid, 1'b0)
			end else begin
				want = exp_q.pop_front();
				`CHK(sword, want)
			end
		end
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// A full image takes about 33.4k cycles at the bench's shift clock
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 45000) begin
			@(posedge clk_i);
			n++;
		end
		if (ready !== 1'b1) begin
			errors++;
			complete_run();
		end
	endtask

	// Strobe stays up so calls in a row go back to back
	task automatic rd(input logic [1:0] s, input logic [6:0] i,
		input logic push, input logic [15:0] e);
		@(posedge clk_i);
		str_rd_i  <= 1'b1;
		str_sel_i <= s;
		str_idx_i <= i;
		if (push)
			exp_q.push_back(e);
	endtask

	task automatic rd_end();
		@(posedge clk_i);
		str_rd_i <= 1'b0;
	endtask

	task automatic load_mem();
		for (int i = 0; i < 128; i++)
			u_mem.img[i] = img[i];
	endtask

	task automatic check_fields(input logic b);
		logic [47:0] st;
		st = {img[0], img[1], img[2], img[3], img[4], img[5]};
		`CHK(blank, b)
		`CHK(station, b ? `ECL_DEF_STATION : st)
		`CHK(power, b ? `ECL_DEF_MAX_PWR : img[8])
		`CHK(poll, b ? `ECL_DEF_POLL : img[9])
		`CHK(en, b | (img[9] != 8'h00))
		`CHK(xcvr, b ? `ECL_DEF_XCVR_INT : img[10][1])
		`CHK(phy, b ? `ECL_DEF_PHY_SEL : img[10][4:2])
		`CHK(integ, b | (img[10][4:2] == 3'h0))
		`CHK(led, b ? `ECL_DEF_LED_SEL : img[11][7:6])
		`CHK(lang, b ? `ECL_DEF_LANG : {img[13], img[12]})
		`CHK(vend, b ? `ECL_DEF_VEND : {img[17], img[16]})
		`CHK(prod, b ? `ECL_DEF_PROD : {img[19], img[18]})
	endtask

	// Every byte of all three descriptors, strobes back to back
	task automatic read_strings();
		logic [7:0] ln, wo, d;
		for (int s = 0; s < 3; s++) begin
			ln = img[8'h14 + 2 * s];
			wo = img[8'h15 + 2 * s];
			for (int i = 0; i < ln; i++) begin
				d = (i == 0) ? ln : (i == 1) ? `ECL_STR_DESC_TYPE :
					img[2 * wo + i];
				rd(s[1:0], i[6:0], 1'b1, {ln, d});
			end
		end
		rd_end();
	endtask

	initial begin
		// Random image, reserved bytes included, endpoint off
		for (int i = 0; i < 128; i++)
			img[i] = $random(seed);
		img[0] = 8'h02;
		img[9] = 8'h00;
		img[8'h14] = 8'h0E;
		img[8'h15] = 8'h10;
		img[8'h16] = 8'h1E;
		img[8'h17] = 8'h18;
		img[8'h18] = 8'h0A;
		img[8'h19] = 8'h38;
		load_mem();
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(2'h0, 7'h00, 1'b0, 16'h0000); // Refused, still loading
		rd_end();
		wait_ready();
		check_fields(1'b0);
		read_strings();
		// Erased station bytes alone must force all defaults
		for (int i = 0; i < 6; i++)
			img[i] = `ECL_ERASED_BYTE;
		load_mem();
		@(posedge clk_i);
		bus_rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		bus_rst_i <= 1'b0;
		rd(2'h1, 7'h00, 1'b0, 16'h0000); // Refused during reload
		rd_end();
		wait_ready();
		check_fields(1'b1);
		rd(2'h0, 7'h00, 1'b1, 16'h0000);
		rd_end();
		repeat (5) @(posedge clk_i);
		`CHK(exp_q.size(), 0)
		complete_run();
	end
endmodule

bind ecl_loader ecl_loader_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.bus_rst_i(bus_rst_i), .str_rd_i(str_rd_i), .mem_cs_o(mem_cs_o),
	.mem_sk_o(mem_sk_o), .cfg_ready_o(cfg_ready_o),
	.image_blank_o(image_blank_o), .station_addr_o(station_addr_o),
	.max_power_o(max_power_o),
	.intr_endpoint_poll_interval_o(intr_endpoint_poll_interval_o),
	.interrupt_in_endpoint_en_o(interrupt_in_endpoint_en_o),
	.phy_operating_select_o(phy_operating_select_o),
	.phy_integrated_o(phy_integrated_o), .str_data_o(str_data_o),
	.str_valid_o(str_valid_o));
